// [rtl/imsc_pkg.sv]
// Constants shared by the interrupt mask and schedule control block
package imsc_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int NUM_UNITS = 4;
   localparam int INPUTS_PER_UNIT = 8;
   localparam int IO_W = 32;
   localparam int NUM_SCHED = 2;
   localparam int STAT_W = 3;
   localparam int DIV_W = 16;

   // Operation and register addresses
   localparam logic [4:0] SET_INTERRUPT_MASK_OP = 5'h00;
   localparam logic [4:0] CLEAR_RECORDED_INTERRUPT_OP = 5'h08;
   localparam logic [4:0] GLOBAL_INTERRUPT_DISABLE_OP = 5'h10;
   localparam logic [4:0] GLOBAL_INTERRUPT_ENABLE_OP = 5'h11;
   localparam logic [4:0] IRQ_STATUS_ADDR = 5'h12;
   localparam logic [4:0] IRQ_MASK_ADDR = 5'h13;
   localparam logic [4:0] CTRL_STATUS_ADDR = 5'h14;
   localparam logic [2:0] FIRST_SCHED_NUM = 3'h4;
   localparam logic [2:0] LAST_SCHED_NUM = 3'h5;

   // Status bit positions
   localparam int STAT_IO_BIT = 0;
   localparam int STAT_SCHED_BIT = 1;
   localparam int STAT_PWR_BIT = 2;

   // Reset values
   localparam logic [31:0] IO_MASK_RST = 32'hFFFFFFFF;
   localparam logic [15:0] INTERVAL_RST = 16'h0000;
   localparam logic GLOBAL_EN_RST = 1'b1;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // Schedule time base
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_UNIT_NS = 100000;
   localparam int TICK_CYCLES = TICK_UNIT_NS / CLK_PERIOD_NS;
endpackage : imsc_pkg

// [rtl/imsc_sync.sv]
// Three-stage input synchroniser with agreement filter and rise detection
`timescale 1ns/1ps
module imsc_sync #(
   parameter int W = 33
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level,
   output logic [W-1:0] rise
);
   import imsc_pkg::*;

   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
      logic [W-1:0] ff3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
   } imsc_sync_s;

   imsc_sync_s s;
   imsc_sync_s next_s;

   always_comb begin
      next_s = s;
      next_s.ff1 = pin_in;
      next_s.ff2 = s.ff1;
      next_s.ff3 = s.ff2;
      // Only a level seen by both later stages counts, so a glitch is dropped
      next_s.lvl = (s.ff2 & s.ff3) | (s.lvl & (s.ff2 | s.ff3));
      next_s.rise = next_s.lvl & ~s.lvl;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.lvl;
   assign rise = s.rise;

   a_rise_agree: assert property (@(posedge clk) disable iff (!nrst)
      s.rise != '0 |-> (s.lvl & s.rise) == s.rise)
      else $error("rise without filtered level");
endmodule : imsc_sync

// [rtl/imsc_sched.sv]
// One scheduled interrupt timer: repeat interval and first-shot delay
`timescale 1ns/1ps
module imsc_sched (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic load_interval,
   input wire logic load_delay,
   input wire logic [imsc_pkg::DATA_W-1:0] wdata,
   output logic [imsc_pkg::DATA_W-1:0] interval,
   output logic [imsc_pkg::DATA_W-1:0] count,
   output logic fire
);
   import imsc_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] interval;
      logic [DATA_W-1:0] count;
      logic fire;
   } imsc_sched_s;

   imsc_sched_s s;
   imsc_sched_s next_s;

   always_comb begin
      next_s = s;
      next_s.fire = 1'b0;
      if (load_interval) begin
         // Zero interval keeps the timer stopped, which is the masked state
         next_s.interval = wdata;
         next_s.count = wdata;
      end else if (load_delay) begin
         next_s.count = wdata;
      end else if (tick && s.interval != INTERVAL_RST) begin
         if (s.count <= 16'h0001) begin
            next_s.fire = 1'b1;
            next_s.count = s.interval;
         end else begin
            next_s.count = s.count - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '{interval: INTERVAL_RST, count: INTERVAL_RST, fire: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign interval = s.interval;
   assign count = s.count;
   assign fire = s.fire;

   a_stopped_quiet: assert property (@(posedge clk) disable iff (!nrst)
      s.interval == INTERVAL_RST && !load_interval |=> !s.fire)
      else $error("stopped timer fired");
   a_fire_reload: assert property (@(posedge clk) disable iff (!nrst)
      tick && !load_interval && !load_delay && s.interval != INTERVAL_RST
      && s.count == 16'h0001 |=> s.fire && s.count == s.interval)
      else $error("timer did not fire and reload");
endmodule : imsc_sched

// [rtl/imsc_ctrl.sv]
// Interrupt mask, recorded-input latch, schedule and global enable control
//
// Contract
// - After reset every I/O input is masked and both scheduled timers are stopped.
// - A mask-set on unit 0 to 3 writes eight mask bits, 1 masking and 0 unmasking.
// - A mask-set on a scheduled number loads the value as its repeat interval.
// - A mask-read returns the current mask byte or interval of the number.
// - A clear on unit 0 to 3 clears recorded inputs whose data bit is 1 and keeps the rest.
// - A clear on number 4 or 5 loads the delay to the first scheduled shot.
// - Global disable blocks every task except the power-off task, which always runs.
// - Global enable re-allows the blocked tasks and leaves every mask unchanged.
`timescale 1ns/1ps
module imsc_ctrl #(
   parameter int TICK_CYCLES = imsc_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [imsc_pkg::ADDR_W-1:0] addr,
   input wire logic [imsc_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [imsc_pkg::DATA_W-1:0] rdata,
   input wire logic [imsc_pkg::IO_W-1:0] io_irq_in,
   input wire logic power_off_in,
   input wire logic [imsc_pkg::IO_W-1:0] io_task_ack,
   input wire logic [imsc_pkg::NUM_SCHED-1:0] sched_task_ack,
   input wire logic power_off_task_ack,
   output logic [imsc_pkg::IO_W-1:0] io_task_pend,
   output logic [imsc_pkg::NUM_SCHED-1:0] sched_task_pend,
   output logic power_off_task_pend,
   output logic irq
);
   import imsc_pkg::*;

   typedef struct packed {
      logic [IO_W-1:0] mask;
      logic [IO_W-1:0] rec;
      logic [NUM_SCHED-1:0] sch_rec;
      logic pwr_rec;
      logic glb_en;
      logic [STAT_W-1:0] stat;
      logic [STAT_W-1:0] imask;
      logic [DATA_W-1:0] rdata;
      logic [DIV_W-1:0] div;
      logic tick;
   } imsc_ctrl_s;

   localparam imsc_ctrl_s STATE_RST = '{
      mask: IO_MASK_RST,
      rec: '0,
      sch_rec: '0,
      pwr_rec: 1'b0,
      glb_en: GLOBAL_EN_RST,
      stat: '0,
      imask: IRQ_MASK_RST,
      rdata: '0,
      div: '0,
      tick: 1'b0
   };
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

   imsc_ctrl_s s;
   imsc_ctrl_s next_s;

   logic [IO_W-1:0] io_rise;
   logic pwr_rise;
   logic [DATA_W-1:0] sch_interval [NUM_SCHED];
   logic [DATA_W-1:0] sch_count [NUM_SCHED];
   logic [NUM_SCHED-1:0] sch_fire;
   logic [NUM_SCHED-1:0] sch_load_int;
   logic [NUM_SCHED-1:0] sch_load_dly;
   logic [2:0] num;
   logic [1:0] unit;
   logic is_set_op;
   logic is_clr_op;
   logic is_read_op;
   logic [IO_W-1:0] clr_bits;

   // Pins are asynchronous to clk; power-off rides in the top bit
   imsc_sync #(
      .W(IO_W + 1)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin_in({power_off_in, io_irq_in}),
      .level(),
      .rise({pwr_rise, io_rise})
   );

   assign num = addr[2:0];
   assign unit = addr[1:0];
   assign is_set_op = wr && addr[4:3] == SET_INTERRUPT_MASK_OP[4:3];
   assign is_clr_op = wr && addr[4:3] == CLEAR_RECORDED_INTERRUPT_OP[4:3];
   assign is_read_op = rd && addr[4:3] == SET_INTERRUPT_MASK_OP[4:3];

   genvar g;
   generate
      for (g = 0; g < NUM_SCHED; g++) begin : g_sched
         assign sch_load_int[g] = is_set_op &&
            num == FIRST_SCHED_NUM + 3'(g);
         assign sch_load_dly[g] = is_clr_op &&
            num == FIRST_SCHED_NUM + 3'(g);
         imsc_sched u_sched (
            .clk(clk),
            .nrst(nrst),
            .tick(s.tick),
            .load_interval(sch_load_int[g]),
            .load_delay(sch_load_dly[g]),
            .wdata(wdata),
            .interval(sch_interval[g]),
            .count(sch_count[g]),
            .fire(sch_fire[g])
         );
      end
   endgenerate

   always_comb begin
      next_s = s;
      clr_bits = '0;

      // Time base divider: one enable pulse per schedule unit
      next_s.tick = 1'b0;
      if (s.div == DIV_LAST) begin
         next_s.div = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div = s.div + 16'h0001;
      end

      // Mask-set on an I/O unit
      if (is_set_op && num < FIRST_SCHED_NUM) begin
         next_s.mask[unit*INPUTS_PER_UNIT +: INPUTS_PER_UNIT] =
            wdata[INPUTS_PER_UNIT-1:0];
      end

      // Clear-or-keep on an I/O unit, one data bit per input
      if (is_clr_op && num < FIRST_SCHED_NUM) begin
         clr_bits[unit*INPUTS_PER_UNIT +: INPUTS_PER_UNIT] =
            wdata[INPUTS_PER_UNIT-1:0];
      end

      // Global disable and enable touch only the enable flag
      if (wr && addr == GLOBAL_INTERRUPT_DISABLE_OP) begin
         next_s.glb_en = 1'b0;
      end
      if (wr && addr == GLOBAL_INTERRUPT_ENABLE_OP) begin
         next_s.glb_en = 1'b1;
      end
      if (wr && addr == IRQ_MASK_ADDR) begin
         next_s.imask = wdata[STAT_W-1:0];
      end

      // Latches record edges whatever the mask; a new edge beats a clear
      next_s.rec = (s.rec & ~clr_bits & ~io_task_ack) | io_rise;
      next_s.sch_rec = (s.sch_rec & ~sched_task_ack) | sch_fire;
      next_s.pwr_rec = (s.pwr_rec & ~power_off_task_ack) | pwr_rise;

      // Status bits are cleared by reading them; events win the same cycle
      if (rd && addr == IRQ_STATUS_ADDR) begin
         next_s.stat = '0;
      end
      next_s.stat[STAT_IO_BIT] = next_s.stat[STAT_IO_BIT] | (|io_rise);
      next_s.stat[STAT_SCHED_BIT] = next_s.stat[STAT_SCHED_BIT] |
         (|sch_fire);
      next_s.stat[STAT_PWR_BIT] = next_s.stat[STAT_PWR_BIT] | pwr_rise;

      // Read data stands only in the cycle after the strobe
      next_s.rdata = '0;
      if (is_read_op) begin
         if (num < FIRST_SCHED_NUM) begin
            next_s.rdata = {8'h00,
               s.mask[unit*INPUTS_PER_UNIT +: INPUTS_PER_UNIT]};
         end else if (num == FIRST_SCHED_NUM) begin
            next_s.rdata = sch_interval[0];
         end else if (num == LAST_SCHED_NUM) begin
            next_s.rdata = sch_interval[1];
         end
      end else if (rd) begin
         case (addr)
            IRQ_STATUS_ADDR: next_s.rdata = {13'h0000, s.stat};
            IRQ_MASK_ADDR: next_s.rdata = {13'h0000, s.imask};
            CTRL_STATUS_ADDR: begin
               next_s.rdata = {12'h000, s.glb_en, s.pwr_rec, s.sch_rec};
            end
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // Masks gate only task raising, so nothing recorded is lost while masked
   assign io_task_pend = s.rec & ~s.mask & {IO_W{s.glb_en}};
   assign sched_task_pend = s.sch_rec & {NUM_SCHED{s.glb_en}};
   assign power_off_task_pend = s.pwr_rec;
   assign irq = |(s.stat & s.imask);
   assign rdata = s.rdata;

   sequence s_enable_op;
      wr && addr == GLOBAL_INTERRUPT_ENABLE_OP;
   endsequence

   sequence s_disable_op;
      wr && addr == GLOBAL_INTERRUPT_DISABLE_OP;
   endsequence

   sequence s_unit_set;
      is_set_op && num < FIRST_SCHED_NUM;
   endsequence

   sequence s_unit_read;
      is_read_op && num < FIRST_SCHED_NUM;
   endsequence

   sequence s_status_read;
      rd && addr == IRQ_STATUS_ADDR;
   endsequence

   sequence s_ctrl_read;
      rd && addr == CTRL_STATUS_ADDR;
   endsequence

   property p_blocked_while_off;
      !s.glb_en |-> io_task_pend == '0 && sched_task_pend == '0;
   endproperty

   a_reset_masks: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nrst) |-> s.mask == IO_MASK_RST && sch_interval[0] == '0
      && sch_interval[1] == '0)
      else $error("not fully masked after reset");

   a_mask_write: assert property (@(posedge clk) disable iff (!nrst)
      s_unit_set |=> s.mask[$past(unit)*INPUTS_PER_UNIT +: INPUTS_PER_UNIT]
      == $past(wdata[7:0]))
      else $error("mask byte not written");

   a_interval_load: assert property (@(posedge clk) disable iff (!nrst)
      is_set_op && num == LAST_SCHED_NUM |=>
      sch_interval[1] == $past(wdata))
      else $error("interval not loaded");

   a_read_back: assert property (@(posedge clk) disable iff (!nrst)
      s_unit_read |=> rdata == {8'h00,
      $past(s.mask[unit*INPUTS_PER_UNIT +: INPUTS_PER_UNIT])})
      else $error("mask read mismatch");

   a_read_sched: assert property (@(posedge clk) disable iff (!nrst)
      is_read_op && num == FIRST_SCHED_NUM |=>
      rdata == $past(sch_interval[0]))
      else $error("interval read mismatch");

   a_clear_rec: assert property (@(posedge clk) disable iff (!nrst)
      is_clr_op && num < FIRST_SCHED_NUM |=>
      (s.rec[$past(unit)*INPUTS_PER_UNIT +: INPUTS_PER_UNIT]
      & $past(wdata[7:0])
      & ~$past(io_rise[unit*INPUTS_PER_UNIT +: INPUTS_PER_UNIT])) == 8'h00)
      else $error("recorded input not cleared");

   a_keep_rec: assert property (@(posedge clk) disable iff (!nrst)
      is_clr_op && num < FIRST_SCHED_NUM && io_task_ack == '0 |=>
      (s.rec & ~$past(clr_bits)) == ($past(s.rec | io_rise) &
      ~$past(clr_bits)))
      else $error("retained input was lost");

   a_first_delay: assert property (@(posedge clk) disable iff (!nrst)
      is_clr_op && num == LAST_SCHED_NUM |=>
      sch_count[1] == $past(wdata))
      else $error("first delay not loaded");

   a_disable_blocks: assert property (@(posedge clk) disable iff (!nrst)
      p_blocked_while_off)
      else $error("task raised while disabled");

   a_disable_op: assert property (@(posedge clk) disable iff (!nrst)
      s_disable_op ##1 !(wr && addr == GLOBAL_INTERRUPT_ENABLE_OP) |=>
      !s.glb_en)
      else $error("disable did not take");

   a_power_off_run: assert property (@(posedge clk) disable iff (!nrst)
      pwr_rise |=> power_off_task_pend)
      else $error("power-off task blocked");

   a_enable_keeps: assert property (@(posedge clk) disable iff (!nrst)
      s_enable_op |=> s.glb_en && $stable(s.mask))
      else $error("enable failed or changed masks");

   a_latch_masked: assert property (@(posedge clk) disable iff (!nrst)
      io_rise != '0 |=> (s.rec & $past(io_rise)) == $past(io_rise))
      else $error("edge not recorded");

   a_latch_raises: assert property (@(posedge clk) disable iff (!nrst)
      s.rec[3] && !io_task_ack[3] && !clr_bits[3] ##1
      (!s.mask[3] && s.glb_en) |-> io_task_pend[3])
      else $error("latched edge did not raise task");

   a_stat_clear: assert property (@(posedge clk) disable iff (!nrst)
      rd && addr == IRQ_STATUS_ADDR && io_rise == '0 && !pwr_rise
      && sch_fire == '0 |=> s.stat == '0 && !irq)
      else $error("status not cleared by read");

   // Idle read data stay zero so a late sample cannot pass by chance
   a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
      !rd |=> rdata == '0)
      else $error("read data outside its cycle");

   a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
      s_ctrl_read |=> rdata[3:0] == {$past(s.glb_en), $past(s.pwr_rec),
      $past(s.sch_rec)})
      else $error("control status read mismatch");

   a_stat_read: assert property (@(posedge clk) disable iff (!nrst)
      s_status_read |=> rdata == {13'h0000, $past(s.stat)})
      else $error("status read mismatch");

   a_stat_sticky: assert property (@(posedge clk) disable iff (!nrst)
      !(rd && addr == IRQ_STATUS_ADDR) |=>
      (s.stat & $past(s.stat)) == $past(s.stat))
      else $error("status bit lost without a read");

   a_pwr_status: assert property (@(posedge clk) disable iff (!nrst)
      pwr_rise |=> s.stat[STAT_PWR_BIT])
      else $error("power-off event not in status");

   a_pwr_ungated: assert property (@(posedge clk) disable iff (!nrst)
      s.pwr_rec |-> power_off_task_pend)
      else $error("power-off task gated");

   a_enabled_pend: assert property (@(posedge clk) disable iff (!nrst)
      s.glb_en |-> io_task_pend == (s.rec & ~s.mask)
      && sched_task_pend == s.sch_rec)
      else $error("enabled task not raised");

   a_clear_keeps_mask: assert property (@(posedge clk) disable iff (!nrst)
      is_clr_op |=> $stable(s.mask))
      else $error("clear changed a mask");

   a_unit_set_sched: assert property (@(posedge clk) disable iff (!nrst)
      s_unit_set |=> $stable(sch_interval[0])
      && $stable(sch_interval[1]))
      else $error("unit mask-set touched an interval");

   // A long pulse would make the timers count several steps per period
   a_tick_pulse: assert property (@(posedge clk) disable iff (!nrst)
      s.tick |=> !s.tick)
      else $error("time base pulse too long");

   a_reenable: assert property (@(posedge clk) disable iff (!nrst)
      s_disable_op ##1 s_enable_op |=> s.glb_en)
      else $error("enable after disable did not take");
endmodule : imsc_ctrl

// [tb/imsc_ctrl_bench.sv]
// Self-checking bench for the interrupt mask and schedule control block
`timescale 1ns/1ps
module imsc_ctrl_bench;
   import imsc_pkg::*;
   // Short tick keeps scheduled periods to a few dozen clocks
   localparam int TICKS = 4;
   logic clk;
   logic nrst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic [IO_W:0] pins;
   logic [IO_W-1:0] io_task_ack;
   logic [NUM_SCHED-1:0] sched_task_ack;
   logic power_off_task_ack;
   logic [IO_W-1:0] io_task_pend;
   logic [NUM_SCHED-1:0] sched_task_pend;
   logic power_off_task_pend;
   logic irq;
   int mismatches;
   int samples_checked;
   int cyc;

   imsc_ctrl #(.TICK_CYCLES(TICKS)) DUT (
      .clk(clk),
      .nrst(nrst),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .io_irq_in(pins[IO_W-1:0]),
      .power_off_in(pins[IO_W]),
      .io_task_ack(io_task_ack),
      .sched_task_ack(sched_task_ack),
      .power_off_task_ack(power_off_task_ack),
      .io_task_pend(io_task_pend),
      .sched_task_pend(sched_task_pend),
      .power_off_task_pend(power_off_task_pend),
      .irq(irq)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("Counts: %0d compared, %0d mismatched", samples_checked,
               mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic wr_op(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_op

   // Read data stand only in the cycle after the strobe
   task automatic rd_op(input logic [4:0] a, input logic [15:0] exp,
                        input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(what, 32'(rdata), 32'(exp));
   endtask : rd_op

   // Pin must fall and settle before it can rise again through the sync
   task automatic pin_pulse(input int b);
      @(posedge clk);
      pins[b] <= 1'b1;
      repeat (6) @(posedge clk);
      pins[b] <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask : pin_pulse

   task automatic ack(input logic [31:0] io, input logic [1:0] s,
                      input logic p);
      @(posedge clk);
      io_task_ack <= io;
      sched_task_ack <= s;
      power_off_task_ack <= p;
      @(posedge clk);
      io_task_ack <= '0;
      sched_task_ack <= '0;
      power_off_task_ack <= 1'b0;
      @(posedge clk);
      #1;
   endtask : ack

   task automatic wait_sched(input int idx, input int lim, output int n);
      n = 0;
      while (sched_task_pend[idx] !== 1'b1 && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : wait_sched

   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("Watchdog expired before the tests ended");
      conclude();
   end

   initial begin
      nrst = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      pins = '0;
      io_task_ack = '0;
      sched_task_ack = '0;
      power_off_task_ack = 1'b0;
      mismatches = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      // Power-up state and interrupt status path
      for (int u = 0; u < 4; u++) begin
         rd_op(5'(u), 16'h00FF, "mask at reset");
      end
      rd_op(5'h04, 16'h0000, "interval 4 at reset");
      rd_op(5'h05, 16'h0000, "interval 5 at reset");
      wr_op(IRQ_MASK_ADDR, 16'h0007);
      rd_op(IRQ_MASK_ADDR, 16'h0007, "irq mask");
      @(posedge clk);
      #1;
      check("rdata idle", 32'(rdata), 32'h0);
      pin_pulse(3);
      check("pend while masked", io_task_pend, 32'h0);
      check("irq on event", 32'(irq), 32'h1);
      rd_op(IRQ_STATUS_ADDR, 16'h0001, "status");
      check("irq after read", 32'(irq), 32'h0);
      rd_op(IRQ_STATUS_ADDR, 16'h0000, "status cleared");
      rd_op(5'h1F, 16'h0000, "unmapped read");
      $display("test reset state done");
      // Mask bits per unit, then the recorded edge on a masked input
      for (int u = 0; u < 4; u++) begin
         wr_op(5'(u), 16'h005A ^ 16'(u));
      end
      for (int u = 0; u < 4; u++) begin
         rd_op(5'(u), 16'h005A ^ 16'(u), "mask readback");
      end
      wr_op(5'h00, 16'h00F7);
      #1;
      check("latched edge raised", io_task_pend, 32'h8);
      ack(32'h8, 2'b00, 1'b0);
      check("pend after ack", io_task_pend, 32'h0);
      wr_op(5'h01, 16'h0000);
      pin_pulse(9);
      check("unmasked input", io_task_pend, 32'h200);
      ack(32'h200, 2'b00, 1'b0);
      $display("test mask set done");
      // Clear one recorded input, keep its neighbour
      wr_op(5'h02, 16'h00FF);
      pin_pulse(16);
      pin_pulse(17);
      check("both masked", io_task_pend, 32'h0);
      wr_op(CLEAR_RECORDED_INTERRUPT_OP + 5'h02, 16'h0001);
      wr_op(5'h02, 16'h0000);
      #1;
      check("clear one keep one", io_task_pend, 32'h0002_0000);
      ack(32'h0002_0000, 2'b00, 1'b0);
      $display("test clear recorded done");
      // Global disable spares only the power-off task
      wr_op(GLOBAL_INTERRUPT_DISABLE_OP, 16'h0000);
      pin_pulse(9);
      check("io blocked", io_task_pend, 32'h0);
      pin_pulse(IO_W);
      check("power off runs", 32'(power_off_task_pend), 32'h1);
      rd_op(CTRL_STATUS_ADDR, 16'h0004, "ctrl while off");
      wr_op(GLOBAL_INTERRUPT_ENABLE_OP, 16'h0000);
      #1;
      check("io after enable", io_task_pend, 32'h200);
      rd_op(5'h01, 16'h0000, "mask kept");
      rd_op(5'h00, 16'h00F7, "mask kept");
      ack(32'h200, 2'b00, 1'b1);
      check("power off acked", 32'(power_off_task_pend), 32'h0);
      rd_op(CTRL_STATUS_ADDR, 16'h0008, "ctrl after enable");
      $display("test global enable done");
      // Scheduled interval and first-shot delay
      wr_op(5'h04, 16'h0003);
      rd_op(5'h04, 16'h0003, "interval readback");
      wait_sched(0, 40, cyc);
      check("first fire", 32'(sched_task_pend[0]), 32'h1);
      ack(32'h0, 2'b01, 1'b0);
      wait_sched(0, 40, cyc);
      check("period", 32'(cyc >= 4 && cyc <= 14), 32'h1);
      wr_op(5'h04, 16'h0000);
      ack(32'h0, 2'b01, 1'b0);
      // Long interval, short delay: only the delay can fire this soon
      wr_op(5'h05, 16'h0064);
      wr_op(CLEAR_RECORDED_INTERRUPT_OP + 5'h05, 16'h0002);
      wait_sched(1, 20, cyc);
      check("delayed first shot", 32'(sched_task_pend[1]), 32'h1);
      wr_op(5'h05, 16'h0000);
      ack(32'h0, 2'b10, 1'b0);
      check("sched idle", 32'(sched_task_pend), 32'h0);
      $display("test scheduled done");
      conclude();
   end
endmodule : imsc_ctrl_bench
